/* File: core/tcd_pkg.sv */
// package: constants and carrier types for the terminal control decoder
package tcd_pkg;
  // ****************************************
  // character codes
  // ****************************************
  localparam logic [6:0] CH_NUL    = 7'h00;
  localparam logic [6:0] CH_ETX    = 7'h03;
  localparam logic [6:0] CH_ENQ    = 7'h05;
  localparam logic [6:0] CH_ACK    = 7'h06;
  localparam logic [6:0] CH_BEL    = 7'h07;
  localparam logic [6:0] CH_VT     = 7'h0b;
  localparam logic [6:0] CH_CR     = 7'h0d;
  localparam logic [6:0] CH_SO     = 7'h0e;
  localparam logic [6:0] CH_SI     = 7'h0f;
  localparam logic [6:0] CH_ESC    = 7'h1b;
  localparam logic [6:0] CH_RUBOUT = 7'h7f;
  // ****************************************
  // character bit positions (bit n is index n-1)
  // ****************************************
  localparam int BIT1_POS = 0;
  localparam int BIT2_POS = 1;
  localparam int BIT6_POS = 5;
  localparam int BIT7_POS = 6;
  localparam int BIT8_POS = 7;
  localparam int BIT9_POS = 8;
  // ****************************************
  // geometry and timing
  // ****************************************
  localparam int  LAST_COLUMN     = 80;
  localparam int  CLK_HZ          = 10_000_000;
  localparam int  DELAY_LONG_MS   = 500;
  localparam int  DELAY_SHORT_MS  = 50;
  localparam int  DELAY_LONG_CYC  = CLK_HZ / 1000 * DELAY_LONG_MS;
  localparam int  DELAY_SHORT_CYC = CLK_HZ / 1000 * DELAY_SHORT_MS;
  localparam int  DELAY_W         = 23;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       strobe;
    logic [8:0] data;
  } tcd_char_t;

  typedef struct packed {
    logic clear_column;
    logic down;
    logic right;
  } tcd_move_t;

  typedef struct packed {
    logic is_nul;
    logic is_etx;
    logic is_enq;
    logic is_ack;
    logic is_bel;
    logic is_vt;
    logic is_cr;
    logic is_so;
    logic is_si;
    logic is_esc;
    logic is_rubout;
    logic is_ctrl;
  } tcd_dec_t;
endpackage : tcd_pkg

/* File: core/tcd_char_decode.sv */
// module: combinational control-character decoder
`timescale 1ns/1ps
`default_nettype none
module tcd_char_decode (
  input  wire logic [8:0]       data,
  input  wire logic             send8,
  output tcd_pkg::tcd_dec_t     dec
);
  import tcd_pkg::*;

  function automatic logic hit(input logic [8:0] d, input logic [6:0] c);
    hit = (d[BIT8_POS] == 1'b0) && (d[6:0] == c);
  endfunction : hit

  // ****************************************
  // decode, blocked entirely in eight-bit send
  // ****************************************
  always_comb begin
    dec           = '0;
    if (!send8) begin
      dec.is_nul    = hit(data, CH_NUL);
      dec.is_etx    = hit(data, CH_ETX);
      dec.is_enq    = hit(data, CH_ENQ);
      dec.is_ack    = hit(data, CH_ACK);
      dec.is_bel    = hit(data, CH_BEL);
      dec.is_vt     = hit(data, CH_VT);
      dec.is_cr     = hit(data, CH_CR);
      dec.is_so     = hit(data, CH_SO);
      dec.is_si     = hit(data, CH_SI);
      dec.is_esc    = hit(data, CH_ESC);
      dec.is_rubout = hit(data, CH_RUBOUT);
      dec.is_ctrl   = (data[BIT8_POS] == 1'b0) && (data[6:5] == 2'b00);
    end
  end
endmodule : tcd_char_decode
`default_nettype wire

/* File: core/tcd_top.sv */
// module: terminal control-character and edit-control decoder
// ****************************************
// What this block does
// - break on full: last row plus down move asserts break at execute
// - page clear or home key clears the page-full break
// - page full drives busy unless busy-on-full option is off
// - direct wrap at column 80 or beyond gives clear_column and down
// - bell from request, protected entry or escape bel, only in retrace
// - rubout suppresses response unless dma active or reset key held
// - nul and etx suppress; etx also spaces right, nul does not
// - with reset key held every control character except rubout spaces right
// - decode si bel cr enq vt etx so ack nul; vt ack idle
// - escape so sends whole buffer, escape si transmittable data only
// - escape latches; next write strobe starts response delay busy
// - prompt in line mode restarts delay; 0.5 s or 50 ms
// - escape then bel issues copy request; hard copy reports busy
// - enter stores etx first, send does not, none if bit 8 true
// - buffer erase-to-end stops at end of line or next attribute
// - direct wrapped erase-to-end does cr and lf at end of line
// - end character closes every buffer send and read cursor
// - attribute bits lock protected fields, non-alpha check, bell on reject
// - cursor blanked during erase, copy, nul, tabbing, separator seek
// - eight-bit send disables control, escape and attribute decoding
// - bit 9 ruling characters not sent unless alternate transmit option
// - host output inhibit forces control data outputs off
// - bit 8 marks attribute code, always protected; bit 2 protection
// ****************************************
`timescale 1ns/1ps
`default_nettype none
module tcd_top #(
  parameter int unsigned DELAY_LONG  = tcd_pkg::DELAY_LONG_CYC,
  parameter int unsigned DELAY_SHORT = tcd_pkg::DELAY_SHORT_CYC
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire tcd_pkg::tcd_char_t rx_char,
  input  wire logic             terminal_write_strobe,
  input  wire logic             key_data,
  input  wire logic             execute_phase,
  input  wire logic             down_move,
  input  wire logic             last_row_cursor_flag,
  input  wire logic [6:0]       cursor_column,
  input  wire logic             end_of_line_cursor,
  input  wire logic             direct_mode,
  input  wire logic             line_mode,
  input  wire logic             dma_active,
  input  wire logic             bell_request,
  input  wire logic             vsync,
  input  wire logic             page_clear,
  input  wire logic             home_key,
  input  wire logic             reset_key,
  input  wire logic             key_submit,
  input  wire logic             key_transmit,
  input  wire logic             erase_to_end_key,
  input  wire logic             read_cursor_done,
  input  wire logic             buffer_send_done,
  input  wire logic             tabbing_skip,
  input  wire logic             separator_seek,
  input  wire logic             field_attribute_flag,
  input  wire logic             field_protected,
  input  wire logic             field_non_alpha,
  input  wire logic             field_non_xmit,
  input  wire logic             hardcopy_busy,
  input  wire logic             host_output_inhibit,
  input  wire logic             eight_bit_send,
  input  wire logic             break_on_full_option,
  input  wire logic             busy_on_full_option,
  input  wire logic             wrap_option,
  input  wire logic             alt_set_xmit_option,
  input  wire logic             short_delay_option,
  input  wire logic [6:0]       prompt_char,
  input  wire logic [6:0]       end_char,
  output logic                  break_out,
  output logic                  terminal_busy_out,
  output logic                  host_response_busy,
  output logic                  escape_latched,
  output tcd_pkg::tcd_move_t    move,
  output logic                  response_suppress,
  output logic                  bell_ring,
  output logic                  copy_request,
  output logic                  send_all,
  output logic                  send_xmit_only,
  output logic                  store_etx,
  output logic                  erase_active,
  output logic                  end_char_valid,
  output logic [6:0]            end_char_out,
  output logic                  keyboard_lock,
  output logic                  write_reject,
  output logic                  char_xmit_ok,
  output logic                  attr_detect,
  output logic                  cursor_blank
);
  import tcd_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] vsync_s, reset_key_s, home_s, hcb_s, ksub_s, ktx_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vsync_s     <= 2'b00;
      reset_key_s <= 2'b00;
      home_s      <= 2'b00;
      hcb_s       <= 2'b00;
      ksub_s      <= 2'b00;
      ktx_s       <= 2'b00;
    end else if (clk_en) begin
      vsync_s     <= {vsync_s[0], vsync};
      reset_key_s <= {reset_key_s[0], reset_key};
      home_s      <= {home_s[0], home_key};
      hcb_s       <= {hcb_s[0], hardcopy_busy};
      ksub_s      <= {ksub_s[0], key_submit};
      ktx_s       <= {ktx_s[0], key_transmit};
    end
  end

  logic vsync_q, rkey_q, home_q, hcb_q, ksub_q, ktx_q;
  assign vsync_q = vsync_s[1];
  assign rkey_q  = reset_key_s[1];
  assign home_q  = home_s[1];
  assign hcb_q   = hcb_s[1];
  assign ksub_q  = ksub_s[1];
  assign ktx_q   = ktx_s[1];

  // ****************************************
  // character decode
  // ****************************************
  tcd_dec_t dec;
  logic     stb;

  tcd_char_decode u_dec (
    .data  (rx_char.data),
    .send8 (eight_bit_send),
    .dec   (dec)
  );

  assign stb = rx_char.strobe;

  // attribute code: bit 8 true, unless eight-bit send masks detection
  logic is_attr;
  assign is_attr = rx_char.data[BIT8_POS] & ~eight_bit_send;

  // ****************************************
  // escape latch and page-full break
  // ****************************************
  logic page_full_r, esc_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      esc_r <= 1'b0;
    end else if (clk_en && stb) begin
      esc_r <= dec.is_esc;  // escape arms only the next character
    end
  end

  // set wins over clear: a down move in the clearing cycle still breaks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_full_r <= 1'b0;
    end else if (clk_en) begin
      if (last_row_cursor_flag && down_move && execute_phase) begin
        page_full_r <= 1'b1;
      end else if (page_clear || home_q) begin
        page_full_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // response delay timer
  // ****************************************
  logic [DELAY_W-1:0] delay_r;
  logic               delay_start;
  assign delay_start = (esc_r && terminal_write_strobe)
                     || (line_mode && stb && !eight_bit_send
                         && rx_char.data[6:0] == prompt_char);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      delay_r <= '0;
    end else if (clk_en) begin
      if (delay_start) begin
        delay_r <= short_delay_option ? DELAY_W'(DELAY_SHORT)
                                      : DELAY_W'(DELAY_LONG);
      end else if (delay_r != '0) begin
        delay_r <= delay_r - 1'b1;
      end
    end
  end

  // ****************************************
  // bell and copy
  // ****************************************
  logic bell_pend_r, copy_seen_r, reject;
  assign reject = key_data && field_attribute_flag
                && (field_protected || (field_non_alpha
                    && rx_char.data[BIT7_POS]));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bell_pend_r <= 1'b0;
    end else if (clk_en) begin
      if (bell_request || reject || (esc_r && stb && dec.is_bel)) begin
        bell_pend_r <= 1'b1;
      end else if (vsync_q) begin
        bell_pend_r <= 1'b0;  // rings during this retrace
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      copy_seen_r <= 1'b0;
    end else if (clk_en) begin
      if (esc_r && stb && dec.is_bel) begin
        copy_seen_r <= 1'b1;
      end else if (hcb_q) begin
        copy_seen_r <= 1'b0;  // unit took it
      end
    end
  end

  // ****************************************
  // erase-to-end
  // ****************************************
  logic erase_r, erase_wrap;
  assign erase_wrap = erase_r && direct_mode && wrap_option
                    && end_of_line_cursor;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      erase_r <= 1'b0;
    end else if (clk_en) begin
      if (erase_to_end_key && !erase_r) begin
        erase_r <= 1'b1;
      end else if (erase_r && (end_of_line_cursor
                   || (!direct_mode && is_attr && stb))) begin
        erase_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // enter and send capture; only enter forms a one-cycle pulse
  // ****************************************
  logic ksub_d, ktx_d, etx_pend_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ksub_d <= 1'b0;
      ktx_d  <= 1'b0;
    end else if (clk_en) begin
      ksub_d <= ksub_q;
      ktx_d  <= ktx_q;
    end
  end

  logic next_right, next_clear_column, next_down, suppress;
  assign next_clear_column  = (direct_mode && wrap_option
                       && cursor_column >= 7'(LAST_COLUMN)) || erase_wrap;
  assign next_down  = next_clear_column;
  assign next_right = stb && ((rkey_q && dec.is_ctrl)
                    || (!rkey_q && dec.is_etx));
  assign suppress   = stb && !rkey_q && (dec.is_nul || dec.is_etx
                    || (dec.is_rubout && !dma_active));

  // ****************************************
  // registered outputs; move, suppress, copy, send, store_etx and end_char_valid gated by host inhibit
  // ****************************************
  logic inh;
  assign inh = host_output_inhibit;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      break_out          <= 1'b0;
      terminal_busy_out  <= 1'b0;
      host_response_busy <= 1'b0;
      escape_latched     <= 1'b0;
      move               <= '0;
      response_suppress  <= 1'b0;
      bell_ring          <= 1'b0;
      copy_request       <= 1'b0;
      send_all           <= 1'b0;
      send_xmit_only     <= 1'b0;
      store_etx          <= 1'b0;
      erase_active       <= 1'b0;
      end_char_valid     <= 1'b0;
      end_char_out       <= 7'h00;
      keyboard_lock      <= 1'b0;
      write_reject       <= 1'b0;
      char_xmit_ok       <= 1'b0;
      attr_detect        <= 1'b0;
      cursor_blank       <= 1'b0;
    end else if (clk_en) begin
      break_out          <= page_full_r && break_on_full_option;
      terminal_busy_out  <= page_full_r && busy_on_full_option;
      host_response_busy <= (delay_r != '0);
      escape_latched     <= esc_r;
      move.clear_column  <= !inh && next_clear_column;
      move.down          <= !inh && next_down;
      move.right         <= !inh && next_right;
      response_suppress  <= !inh && suppress;
      // bell only rings in retrace
      bell_ring          <= bell_pend_r && vsync_q;
      copy_request       <= !inh && copy_seen_r;
      send_all           <= !inh && esc_r && stb && dec.is_so;
      send_xmit_only     <= !inh && esc_r && stb && dec.is_si;
      // enter stores etx unless bit 8 set; send stores nothing
      store_etx          <= !inh && ksub_q && !ksub_d
                            && !rx_char.data[BIT8_POS];
      erase_active       <= erase_r;
      end_char_valid     <= !inh && (buffer_send_done
                                     || read_cursor_done);
      end_char_out       <= end_char;
      keyboard_lock      <= field_attribute_flag
                            && field_protected;
      write_reject       <= reject;
      char_xmit_ok       <= !field_non_xmit
                            && (!rx_char.data[BIT9_POS]
                                || alt_set_xmit_option);
      attr_detect        <= is_attr;
      cursor_blank       <= erase_r || hcb_q || copy_seen_r
                            || (stb && dec.is_nul) || tabbing_skip
                            || separator_seek;
    end
  end
endmodule : tcd_top
`default_nettype wire

/* File: testbench/tcd_properties.sv */
// checker: port-level properties of the control decoder
`timescale 1ns/1ps
`default_nettype none
module tcd_properties #(
  parameter int unsigned DELAY_LONG  = 20,
  parameter int unsigned DELAY_SHORT = 5
) (
  input wire logic                mclk, rst_n, clk_en, dma_active, reset_key,
  input wire logic                eight_bit_send, host_output_inhibit, vsync,
  input wire logic                break_on_full_option, busy_on_full_option,
  input wire logic                last_row_cursor_flag, down_move, home_key,
  input wire logic                execute_phase, page_clear,
  input wire tcd_pkg::tcd_char_t  rx_char,
  input wire tcd_pkg::tcd_move_t  move,
  input wire logic                response_suppress, escape_latched, bell_ring,
  input wire logic                copy_request, host_response_busy, send_all,
  input wire logic                send_xmit_only, store_etx, end_char_valid,
  input wire logic                break_out, terminal_busy_out
);
  import tcd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic        ok;
  logic [15:0] bcnt_r;
  // decoding is live only when nothing masks it
  assign ok = clk_en && !eight_bit_send && !host_output_inhibit
              && !dma_active && !reset_key;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) bcnt_r <= '0;
    else if (!host_response_busy) bcnt_r <= '0;
    else if (clk_en) bcnt_r <= bcnt_r + 16'h0001;
  end
  rubout_supp_a: assert property (ok && rx_char.strobe
    && rx_char.data == {2'b00, CH_RUBOUT} |-> ##[1:2] response_suppress)
    else $error("rubout not suppressed");
  etx_space_a: assert property (ok && rx_char.strobe
    && rx_char.data == {2'b00, CH_ETX} |-> ##[1:2] move.right)
    else $error("etx did not space right");
  esc_latch_a: assert property (ok && rx_char.strobe
    && rx_char.data == {2'b00, CH_ESC} |-> ##[1:2] escape_latched)
    else $error("escape not latched");
  esc_copy_a: assert property (ok && rx_char.strobe
    && rx_char.data == {2'b00, CH_ESC} ##1 ok && rx_char.strobe
    && rx_char.data == {2'b00, CH_BEL} |-> ##[1:2] copy_request)
    else $error("escape bel gave no copy request");
  send8_esc_a: assert property (rx_char.strobe && eight_bit_send
    && $past(eight_bit_send) && !escape_latched
    && rx_char.data == {2'b00, CH_ESC} |=> !escape_latched[*2])
    else $error("escape decoded in eight-bit send");
  busy_len_a: assert property ($fell(host_response_busy)
    |-> bcnt_r >= 16'(DELAY_SHORT))
    else $error("response busy too short");
  inhibit_quiet_a: assert property (host_output_inhibit
    && $past(host_output_inhibit) |-> move == '0 && !send_all
    && !send_xmit_only && !store_etx && !end_char_valid && !copy_request)
    else $error("output while host inhibit");
  bell_retrace_a: assert property (bell_ring |-> $past(vsync, 2)
    || $past(vsync, 3) || $past(vsync, 4))
    else $error("bell outside retrace");
  break_full_a: assert property (break_on_full_option && clk_en
    && last_row_cursor_flag && down_move && execute_phase && !page_clear
    && !home_key |-> ##[1:3] break_out)
    else $error("no break on page full");
  busy_full_a: assert property (!busy_on_full_option
    && !$past(busy_on_full_option) && !$past(busy_on_full_option, 2)
    |-> !terminal_busy_out)
    else $error("busy on full while option off");
endmodule : tcd_properties
bind tcd_top tcd_properties #(.DELAY_LONG(DELAY_LONG),
  .DELAY_SHORT(DELAY_SHORT)) u_props (.*);
`default_nettype wire

/* File: testbench/tcd_host_model.sv */
// partner: host side feeding characters and the output inhibit
`timescale 1ns/1ps
`default_nettype none
module tcd_host_model (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          req,
  input  wire logic          req_esc,
  input  wire logic [8:0]    req_data,
  input  wire logic          req_inhibit,
  output tcd_pkg::tcd_char_t rx_char,
  output logic               host_output_inhibit
);
  import tcd_pkg::*;
  logic       pend_r;
  logic [8:0] code_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r  <= 1'b0;
      code_r  <= '0;
      rx_char <= '0;
    end else begin
      rx_char.strobe <= 1'b0;
      // stale data is not held, so nobody can lean on it
      rx_char.data <= ~rx_char.data;
      if (pend_r) begin
        rx_char <= {1'b1, code_r};
        pend_r  <= 1'b0;
      end else if (req && req_esc) begin
        rx_char <= {1'b1, 2'b00, CH_ESC};
        code_r  <= req_data;
        pend_r  <= 1'b1;
      end else if (req) begin
        rx_char <= {1'b1, req_data};
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) host_output_inhibit <= 1'b0;
    else host_output_inhibit <= req_inhibit;
  end
endmodule : tcd_host_model
`default_nettype wire

/* File: testbench/testbench.sv */
// testbench: directed scenarios for the control decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tcd_pkg::*;
  localparam int unsigned DL = 20;
  localparam int unsigned DS = 5;
  logic mclk, rst_n, clk_en, terminal_write_strobe, key_data, execute_phase;
  logic down_move, last_row_cursor_flag, end_of_line_cursor, direct_mode;
  logic line_mode, dma_active, bell_request, vsync, page_clear, home_key;
  logic reset_key, key_submit, key_transmit, erase_to_end_key;
  logic read_cursor_done, buffer_send_done, tabbing_skip, separator_seek;
  logic field_attribute_flag, field_protected, field_non_alpha;
  logic field_non_xmit, hardcopy_busy, host_output_inhibit, eight_bit_send;
  logic break_on_full_option, busy_on_full_option, wrap_option;
  logic alt_set_xmit_option, short_delay_option, req, req_esc, req_inhibit;
  logic [6:0] cursor_column, prompt_char, end_char, end_char_out;
  logic [8:0] req_data;
  logic break_out, terminal_busy_out, host_response_busy, escape_latched;
  logic response_suppress, bell_ring, copy_request, send_all, store_etx;
  logic send_xmit_only, erase_active, end_char_valid, keyboard_lock;
  logic write_reject, char_xmit_ok, attr_detect, cursor_blank;
  tcd_char_t rx_char;
  tcd_move_t move;
  int error_cnt, total_checks;
  tcd_top #(.DELAY_LONG(DL), .DELAY_SHORT(DS)) dut (.*);
  tcd_host_model host (.*);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic check(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t flag mismatch", $time);
    end
  endtask : check
  task automatic check_n(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("[FAIL] %0t count %0d not %0d", $time, got, exp);
    end
  endtask : check_n
  function automatic logic pick(input int s);
    case (s)
      0: pick = response_suppress;
      1: pick = move.right;
      2: pick = send_all;
      3: pick = send_xmit_only;
      4: pick = copy_request;
      5: pick = escape_latched;
      6: pick = break_out;
      7: pick = terminal_busy_out;
      8: pick = host_response_busy;
      10: pick = move.clear_column;
      11: pick = cursor_blank;
      12: pick = keyboard_lock && write_reject;
      13: pick = char_xmit_ok;
      14: pick = end_char_valid;
      15: pick = erase_active;
      default: pick = bell_ring;
    endcase
  endfunction : pick
  // look up to n cycles for output s at v; absence is only legal if exp low
  task automatic expect_evt(input int s, input logic v, input int n,
                            input logic exp);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      @(negedge mclk);
      hit = (pick(s) === v);
    end
    @(posedge mclk);
    check(hit, exp);
    if (!hit && exp) wrap_up();
  endtask : expect_evt
  task automatic send(input logic esc, input logic [8:0] d);
    @(posedge mclk);
    req      <= 1'b1;
    req_esc  <= esc;
    req_data <= d;
    @(posedge mclk);
    req <= 1'b0;
  endtask : send
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  task automatic t_chars;
    send(0, {2'b00, CH_RUBOUT});
    expect_evt(0, 1, 4, 1);
    dma_active <= 1'b1;
    send(0, {2'b00, CH_RUBOUT});
    expect_evt(0, 1, 4, 0);
    dma_active <= 1'b0;
    send(0, {2'b00, CH_NUL});
    expect_evt(1, 1, 4, 0);
    send(0, {2'b00, CH_ETX});
    expect_evt(1, 1, 4, 1);
    send(0, {2'b00, CH_VT});
    expect_evt(0, 1, 4, 0);
    send(0, {2'b00, CH_ACK});
    expect_evt(1, 1, 4, 0);
    reset_key <= 1'b1;
    idle(4);
    send(0, {2'b00, CH_CR});
    expect_evt(1, 1, 4, 1);
    send(0, {2'b00, CH_RUBOUT});
    expect_evt(0, 1, 4, 0);
    reset_key <= 1'b0;
    idle(4);
  endtask : t_chars
  task automatic t_escape;
    send(1, {2'b00, CH_SO});
    expect_evt(2, 1, 6, 1);
    send(1, {2'b00, CH_SI});
    expect_evt(3, 1, 6, 1);
    send(1, {2'b00, CH_BEL});
    expect_evt(4, 1, 6, 1);
    vsync <= 1'b1;
    expect_evt(9, 1, 6, 1);
    vsync <= 1'b0;
    hardcopy_busy <= 1'b1;
    expect_evt(4, 0, 8, 1);
    hardcopy_busy <= 1'b0;
    req_inhibit <= 1'b1;
    idle(3);
    send(1, {2'b00, CH_SO});
    expect_evt(2, 1, 6, 0);
    req_inhibit <= 1'b0;
    eight_bit_send <= 1'b1;
    send(0, {2'b00, CH_ESC});
    expect_evt(5, 1, 4, 0);
    eight_bit_send <= 1'b0;
  endtask : t_escape
  // busy window length, in cycles, after a trigger already seen
  task automatic t_delay;
    int n;
    send(0, {2'b00, CH_ESC});
    expect_evt(5, 1, 4, 1);
    @(posedge mclk);
    terminal_write_strobe <= 1'b1;
    @(posedge mclk);
    terminal_write_strobe <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      expect_evt(8, 1, 4, 1);
      n = 1;
      @(negedge mclk);
      while (host_response_busy === 1'b1 && n < 200) begin
        n++;
        @(negedge mclk);
      end
      check_n(n, k ? DS : DL);
      short_delay_option <= 1'b1;
      line_mode <= 1'b1;
      send(0, {2'b00, prompt_char});
    end
  endtask : t_delay
  task automatic full(input logic brk, input logic bsy);
    break_on_full_option <= brk;
    busy_on_full_option <= bsy;
    idle(3);
    {last_row_cursor_flag, down_move, execute_phase} <= 3'b111;
    @(posedge mclk);
    {last_row_cursor_flag, down_move, execute_phase} <= 3'b000;
  endtask : full
  task automatic t_full;
    full(0, 1);
    expect_evt(6, 1, 5, 0);
    check(terminal_busy_out, 1'b1);
    page_clear <= 1'b1;
    expect_evt(7, 0, 5, 1);
    page_clear <= 1'b0;
    full(1, 0);
    expect_evt(6, 1, 5, 1);
    expect_evt(7, 1, 3, 0);
    home_key <= 1'b1;
    expect_evt(6, 0, 8, 1);
    home_key <= 1'b0;
  endtask : t_full
  task automatic t_edit;
    {direct_mode, wrap_option} <= 2'b11;
    cursor_column <= 7'(LAST_COLUMN);
    expect_evt(10, 1, 4, 1);
    {direct_mode, cursor_column} <= '0;
    {field_attribute_flag, field_protected, key_data} <= 3'b111;
    expect_evt(12, 1, 4, 1);
    {field_attribute_flag, field_protected, key_data} <= 3'b000;
    buffer_send_done <= 1'b1;
    expect_evt(14, 1, 4, 1);
    check(end_char_out === end_char, 1'b1);
    buffer_send_done <= 1'b0;
    erase_to_end_key <= 1'b1;
    expect_evt(15, 1, 4, 1);
    erase_to_end_key <= 1'b0;
    expect_evt(11, 1, 4, 1);
    end_of_line_cursor <= 1'b1;
    expect_evt(15, 0, 4, 1);
    end_of_line_cursor <= 1'b0;
    alt_set_xmit_option <= 1'b1;
    idle(1);
    expect_evt(13, 0, 4, 0);
    alt_set_xmit_option <= 1'b0;
    expect_evt(13, 0, 4, 1);
  endtask : t_edit
  initial begin
    {rst_n, terminal_write_strobe, key_data, execute_phase, down_move} = '0;
    {last_row_cursor_flag, end_of_line_cursor, direct_mode, line_mode} = '0;
    {dma_active, bell_request, vsync, page_clear, home_key, reset_key} = '0;
    {key_submit, key_transmit, erase_to_end_key, read_cursor_done} = '0;
    {buffer_send_done, tabbing_skip, separator_seek, hardcopy_busy} = '0;
    {field_attribute_flag, field_protected, field_non_alpha} = '0;
    {field_non_xmit, eight_bit_send, break_on_full_option, wrap_option} = '0;
    {alt_set_xmit_option, short_delay_option, req, req_esc} = '0;
    {req_inhibit, req_data, cursor_column} = '0;
    busy_on_full_option = 1'b1;
    clk_en = 1'b1;
    prompt_char = 7'h3f;
    end_char = 7'h04;
    error_cnt = 0;
    total_checks = 0;
    idle(4);
    rst_n <= 1'b1;
    @(negedge mclk);
    check(escape_latched | break_out | host_response_busy, 1'b0);
    check(terminal_busy_out, 1'b0);
    t_chars();
    t_escape();
    t_delay();
    t_full();
    t_edit();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
